// [design/port_split_map.svh]
/*
 Register offsets, reset values, field positions and timing counts of the
 port split and link timeout block. Assumes a 50 MHz core clock.
*/
`ifndef PORT_SPLIT_MAP_SVH
`define PORT_SPLIT_MAP_SVH

`define SPLIT_ENABLE_ADDR 16'h3C48
`define P5_PIN_SEL_ADDR 16'h416E
`define P6_PIN_SEL_ADDR 16'h416F
`define TIMEOUT_SEL_ADDR 16'h4171
`define PULSE_WIDTH_ADDR 16'h4176

`define SPLIT_ENABLE_RST 8'h00
`define SPLIT_ENABLE_MASK 8'h60
`define P5_BIT 5
`define P6_BIT 6
`define P5_SEL_RST 8'h42
`define P6_SEL_RST 8'h06
`define TIMEOUT_SEL_RST 8'h05
`define PULSE_WIDTH_RST 8'h05

`define P5_OPT_A 8'h42
`define P5_OPT_B 8'h05
`define P6_OPT_A 8'h06
`define P6_OPT_B 8'h04

`define STUCK_LO 4'h4
`define STUCK_HI 4'h9

`define CLK_KHZ 50000
`define TICK_MS 10
`define TICK_CYCLES (`TICK_MS * `CLK_KHZ)
`define TIMEOUT_STEP_MS 200
`define TIMEOUT_STEP_TICKS (`TIMEOUT_STEP_MS / `TICK_MS)
`define PULSE_BASE_MS 350
`define PULSE_BASE_TICKS (`PULSE_BASE_MS / `TICK_MS)

`endif

// [design/port_split_pkg.sv]
/*
 Types shared by the port split controller and its link watchdogs.
 Assumes port_split_map.svh is compiled alongside.
*/
package port_split_pkg;
    typedef enum logic [2:0]
    {
        WD_IDLE = 3'h1,
        WD_WATCH = 3'h2,
        WD_PULSE = 3'h4
    } wd_state_t;

    typedef logic [15:0] tick_count_t;
    typedef logic [3:0] link_state_t;
endpackage

// [design/link_watchdog_if.sv]
/*
 Carrier between the split controller and one link watchdog.
 Assumes both sides run on the same core clock.
*/
interface link_watchdog_if;
    logic enable;
    logic tick;
    port_split_pkg::tick_count_t timeout_ticks;
    port_split_pkg::tick_count_t pulse_ticks;
    port_split_pkg::link_state_t link_state;
    logic power_out;
    logic resetting;

    modport ctl
    (
        output enable, tick, timeout_ticks, pulse_ticks, link_state,
        input power_out, resetting
    );
    modport wd
    (
        input enable, tick, timeout_ticks, pulse_ticks, link_state,
        output power_out, resetting
    );
endinterface

// [design/link_watchdog.sv]
/*
 Per-port link watchdog: counts ticks while the link sits in one stuck
 state and drives a low power pulse on expiry. Assumes a tick pulse from
 the controller's divider and a link state synchronous to the clock.
*/
`include "port_split_map.svh"

module link_watchdog
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Controller side
    link_watchdog_if.wd wd
);
    port_split_pkg::wd_state_t state_ff, nxt_state;
    port_split_pkg::tick_count_t cnt_ff, nxt_cnt;
    port_split_pkg::link_state_t prev_ff, nxt_prev;
    logic power_ff, nxt_power;
    logic stuck;
    logic restart;

    assign stuck = (wd.link_state >= `STUCK_LO) && (wd.link_state <= `STUCK_HI);
    assign restart = !stuck || (wd.link_state != prev_ff);

    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_prev = wd.link_state;
        case (state_ff)
            port_split_pkg::WD_IDLE:
            begin
                nxt_cnt = '0;
                if (wd.enable && wd.timeout_ticks != '0)
                    nxt_state = port_split_pkg::WD_WATCH;
            end
            port_split_pkg::WD_WATCH:
            begin
                if (!wd.enable || wd.timeout_ticks == '0)
                    nxt_state = port_split_pkg::WD_IDLE;
                else if (restart)
                    nxt_cnt = '0;
                else if (wd.tick)
                begin
                    if (cnt_ff + 16'h0001 >= wd.timeout_ticks)
                    begin
                        nxt_state = port_split_pkg::WD_PULSE;
                        nxt_cnt = '0;
                    end
                    else
                        nxt_cnt = cnt_ff + 16'h0001;
                end
            end
            port_split_pkg::WD_PULSE:
            begin
                if (!wd.enable)
                    nxt_state = port_split_pkg::WD_IDLE;
                else if (wd.tick)
                begin
                    if (cnt_ff + 16'h0001 >= wd.pulse_ticks)
                    begin
                        nxt_state = port_split_pkg::WD_WATCH;
                        nxt_cnt = '0;
                    end
                    else
                        nxt_cnt = cnt_ff + 16'h0001;
                end
            end
            default:
            begin
                nxt_state = port_split_pkg::WD_IDLE;
                nxt_cnt = '0;
            end
        endcase
        nxt_power = wd.enable && (nxt_state != port_split_pkg::WD_PULSE);
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            state_ff <= port_split_pkg::WD_IDLE;
            cnt_ff <= '0;
            prev_ff <= '0;
            power_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            prev_ff <= nxt_prev;
            power_ff <= nxt_power;
        end
    end

    assign wd.power_out = power_ff;
    assign wd.resetting = (state_ff == port_split_pkg::WD_PULSE);

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    sequence seq_expire;
        state_ff == port_split_pkg::WD_WATCH && wd.enable && wd.timeout_ticks != '0
            && !restart && wd.tick && cnt_ff + 16'h0001 >= wd.timeout_ticks;
    endsequence

    sequence seq_pulse_done;
        state_ff == port_split_pkg::WD_PULSE && wd.enable && wd.tick
            && cnt_ff + 16'h0001 >= wd.pulse_ticks;
    endsequence

    a_expiry_starts_pulse: assert property (seq_expire |=> wd.resetting && cnt_ff == '0
        && !wd.power_out)
        else $error("expiry did not start a clean power pulse");
    a_pulse_holds_low: assert property (wd.resetting |-> !wd.power_out)
        else $error("power output high during link reset");
    a_pulse_restarts: assert property (seq_pulse_done
        |=> state_ff == port_split_pkg::WD_WATCH && cnt_ff == '0 ##0 wd.power_out)
        else $error("watchdog did not restart after pulse");
    a_change_restarts: assert property (state_ff == port_split_pkg::WD_WATCH && wd.enable
        && wd.timeout_ticks != '0 && restart |=> cnt_ff == '0)
        else $error("stuck window not restarted");
    a_zero_disables: assert property (state_ff == port_split_pkg::WD_WATCH
        && wd.timeout_ticks == '0 |=> state_ff == port_split_pkg::WD_IDLE)
        else $error("zero timeout did not stop watchdog");
    a_stuck_counts: assert property (state_ff == port_split_pkg::WD_WATCH && wd.enable
        && wd.timeout_ticks != '0 && !restart && wd.tick
        && cnt_ff + 16'h0001 < wd.timeout_ticks |=> cnt_ff == $past(cnt_ff) + 16'h0001)
        else $error("stuck state not counted");
endmodule

// [design/port_split_ctrl.sv]
/*
 Port split controller for downstream ports 5 and 6: configuration
 registers, tick divider, split power pin routing and the two link
 watchdogs. Assumes configuration writes arrive only from the SMBus
 slave during the configuration stage, and OTP values from the loader.
*/
`include "port_split_map.svh"

module port_split_ctrl
#(
    parameter int unsigned TICK_CYCLES = `TICK_CYCLES
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Configuration register port
    input wire logic cfg_stage,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [15:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    output logic [7:0] cfg_rdata,
    output logic cfg_rvalid,
    // OTP loader
    input wire logic otp_load,
    input wire logic [7:0] otp_split_enable,
    input wire logic [7:0] otp_p5_pin_select,
    input wire logic [7:0] otp_p6_pin_select,
    input wire logic [7:0] otp_pulse_width,
    input wire logic otp_timeout_override,
    input wire logic [7:0] otp_timeout_select,
    // Hub core port power requests and link state
    input wire logic [1:0] port_power_req,
    input wire logic [3:0] p5_link_training_state_status,
    input wire logic [3:0] p6_link_training_state_status,
    // Legacy power pins
    output logic [1:0] legacy_port_power_ctrl,
    // Split power pins, output enable low while driven
    output logic port5_option_a_pin,
    output logic port5_option_a_pin_oe_n,
    output logic port5_option_b_pin,
    output logic port5_option_b_pin_oe_n,
    output logic port6_option_a_pin,
    output logic port6_option_a_pin_oe_n,
    output logic port6_option_b_pin,
    output logic port6_option_b_pin_oe_n,
    // Status
    output logic [1:0] link_reset_active
);
    logic [7:0] split_en_ff, nxt_split_en;
    logic [7:0] p5_sel_ff, nxt_p5_sel;
    logic [7:0] p6_sel_ff, nxt_p6_sel;
    logic [7:0] timeout_ff, nxt_timeout;
    logic [7:0] pulse_ff, nxt_pulse;
    logic [7:0] rdata_ff, nxt_rdata;
    logic rvalid_ff, nxt_rvalid;
    logic [31:0] div_ff, nxt_div;
    logic tick;
    logic [1:0] legacy_ff, nxt_legacy;
    logic [3:0] pin_ff, nxt_pin;
    logic [3:0] pin_oe_n_ff, nxt_pin_oe_n;
    logic [7:0] eff_timeout;
    logic wr_ok;

    link_watchdog_if wd5();
    link_watchdog_if wd6();

    // Decoded register read; unmapped offsets answer zero
    function automatic logic [7:0] read_reg(input logic [15:0] addr);
        case (addr)
            `SPLIT_ENABLE_ADDR: read_reg = split_en_ff;
            `P5_PIN_SEL_ADDR: read_reg = p5_sel_ff;
            `P6_PIN_SEL_ADDR: read_reg = p6_sel_ff;
            `TIMEOUT_SEL_ADDR: read_reg = timeout_ff;
            `PULSE_WIDTH_ADDR: read_reg = pulse_ff;
            default: read_reg = 8'h00;
        endcase
    endfunction

    // Timeout select counts in 200 ms steps of 10 ms ticks
    function automatic port_split_pkg::tick_count_t timeout_ticks(input logic [7:0] sel);
        timeout_ticks = 16'(sel) * 16'(`TIMEOUT_STEP_TICKS);
    endfunction

    // Pulse width counts 10 ms steps above 350 ms: 0x05 gives 400 ms, 0xFF 2.9 s
    function automatic port_split_pkg::tick_count_t pulse_ticks(input logic [7:0] sel);
        pulse_ticks = 16'(`PULSE_BASE_TICKS) + 16'(sel);
    endfunction

    // Routes one port's split power to option A or B; unknown codes drive nothing
    function automatic logic [1:0] pin_route(input logic [7:0] sel, input logic [7:0] opt_a,
        input logic [7:0] opt_b);
        pin_route = {sel == opt_b, sel == opt_a};
    endfunction

    // Only configuration-stage writes reach the registers
    assign wr_ok = cfg_wr && cfg_stage;

    always_comb
    begin
        nxt_split_en = split_en_ff;
        nxt_p5_sel = p5_sel_ff;
        nxt_p6_sel = p6_sel_ff;
        nxt_timeout = timeout_ff;
        nxt_pulse = pulse_ff;
        if (otp_load)
        begin
            nxt_split_en = otp_split_enable & `SPLIT_ENABLE_MASK;
            nxt_p5_sel = otp_p5_pin_select;
            nxt_p6_sel = otp_p6_pin_select;
            nxt_pulse = otp_pulse_width;
        end
        else if (wr_ok)
        begin
            case (cfg_addr)
                // Reserved bits and read-only bit 0 stay zero
                `SPLIT_ENABLE_ADDR: nxt_split_en = cfg_wdata & `SPLIT_ENABLE_MASK;
                `P5_PIN_SEL_ADDR: nxt_p5_sel = cfg_wdata;
                `P6_PIN_SEL_ADDR: nxt_p6_sel = cfg_wdata;
                `TIMEOUT_SEL_ADDR: nxt_timeout = cfg_wdata;
                `PULSE_WIDTH_ADDR: nxt_pulse = cfg_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            split_en_ff <= `SPLIT_ENABLE_RST;
            p5_sel_ff <= `P5_SEL_RST;
            p6_sel_ff <= `P6_SEL_RST;
            timeout_ff <= `TIMEOUT_SEL_RST;
            pulse_ff <= `PULSE_WIDTH_RST;
        end
        else
        begin
            split_en_ff <= nxt_split_en;
            p5_sel_ff <= nxt_p5_sel;
            p6_sel_ff <= nxt_p6_sel;
            timeout_ff <= nxt_timeout;
            pulse_ff <= nxt_pulse;
        end
    end

    // Read answer one cycle after the strobe
    always_comb
    begin
        nxt_rvalid = cfg_rd;
        nxt_rdata = cfg_rd ? read_reg(cfg_addr) : rdata_ff;
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            rdata_ff <= 8'h00;
            rvalid_ff <= 1'b0;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    assign cfg_rdata = rdata_ff;
    assign cfg_rvalid = rvalid_ff;

    // OTP override wins over the register copy, which stays readable
    assign eff_timeout = otp_timeout_override ? otp_timeout_select : timeout_ff;

    // 10 ms tick shared by both watchdogs
    always_comb
    begin
        if (div_ff >= TICK_CYCLES - 1)
            nxt_div = '0;
        else
            nxt_div = div_ff + 32'h0000_0001;
    end

    always_ff @(posedge clock)
    begin
        if (srst)
            div_ff <= '0;
        else
            div_ff <= nxt_div;
    end

    assign tick = (div_ff >= TICK_CYCLES - 1);

    assign wd5.enable = split_en_ff[`P5_BIT];
    assign wd5.tick = tick;
    assign wd5.timeout_ticks = timeout_ticks(eff_timeout);
    assign wd5.pulse_ticks = pulse_ticks(pulse_ff);
    assign wd5.link_state = p5_link_training_state_status;

    assign wd6.enable = split_en_ff[`P6_BIT];
    assign wd6.tick = tick;
    assign wd6.timeout_ticks = timeout_ticks(eff_timeout);
    assign wd6.pulse_ticks = pulse_ticks(pulse_ff);
    assign wd6.link_state = p6_link_training_state_status;

    link_watchdog u_wd5
    (
        .clock(clock),
        .srst(srst),
        .wd(wd5.wd)
    );

    link_watchdog u_wd6
    (
        .clock(clock),
        .srst(srst),
        .wd(wd6.wd)
    );

    // Pin drive; no overcurrent input exists on the split power pins
    always_comb
    begin
        logic [1:0] r5;
        logic [1:0] r6;
        r5 = pin_route(p5_sel_ff, `P5_OPT_A, `P5_OPT_B);
        r6 = pin_route(p6_sel_ff, `P6_OPT_A, `P6_OPT_B);
        nxt_legacy = port_power_req;
        nxt_pin = {wd6.power_out & r6[1], wd6.power_out & r6[0],
            wd5.power_out & r5[1], wd5.power_out & r5[0]};
        nxt_pin_oe_n = ~{split_en_ff[`P6_BIT] & r6[1], split_en_ff[`P6_BIT] & r6[0],
            split_en_ff[`P5_BIT] & r5[1], split_en_ff[`P5_BIT] & r5[0]};
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            legacy_ff <= 2'h0;
            pin_ff <= 4'h0;
            pin_oe_n_ff <= 4'hF;
        end
        else
        begin
            legacy_ff <= nxt_legacy;
            pin_ff <= nxt_pin;
            pin_oe_n_ff <= nxt_pin_oe_n;
        end
    end

    assign legacy_port_power_ctrl = legacy_ff;
    assign port5_option_a_pin = pin_ff[0];
    assign port5_option_b_pin = pin_ff[1];
    assign port6_option_a_pin = pin_ff[2];
    assign port6_option_b_pin = pin_ff[3];
    assign port5_option_a_pin_oe_n = pin_oe_n_ff[0];
    assign port5_option_b_pin_oe_n = pin_oe_n_ff[1];
    assign port6_option_a_pin_oe_n = pin_oe_n_ff[2];
    assign port6_option_b_pin_oe_n = pin_oe_n_ff[3];
    assign link_reset_active = {wd6.resetting, wd5.resetting};

    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    a_legacy_follows: assert property (##1 legacy_port_power_ctrl == $past(port_power_req))
        else $error("legacy power pin does not follow request");
    a_reserved_zero: assert property ((split_en_ff & ~`SPLIT_ENABLE_MASK) == 8'h00)
        else $error("reserved split enable bit set");
    a_cfg_gated: assert property (cfg_wr && !cfg_stage && !otp_load |=> $stable(split_en_ff)
        && $stable(timeout_ff) && $stable(pulse_ff))
        else $error("register changed outside configuration stage");
    a_p5_opt_b: assert property (split_en_ff[`P5_BIT] && p5_sel_ff == `P5_OPT_B
        |=> !port5_option_b_pin_oe_n && port5_option_a_pin_oe_n)
        else $error("port 5 option B pin not driven");
    a_p6_opt_a: assert property (split_en_ff[`P6_BIT] && p6_sel_ff == `P6_OPT_A
        |=> !port6_option_a_pin_oe_n && port6_option_b_pin_oe_n)
        else $error("port 6 option A pin not driven");
    a_split_off_idle: assert property (!split_en_ff[`P5_BIT] |=> port5_option_a_pin_oe_n
        && port5_option_b_pin_oe_n)
        else $error("split pin driven while port 5 not split");
    a_reset_low: assert property (wd5.resetting
        |=> !port5_option_a_pin && !port5_option_b_pin)
        else $error("split power not low during link reset");
    // Pins lag the registered select and enable by one cycle
    a_p5_opt_a: assert property (split_en_ff[`P5_BIT] && p5_sel_ff == `P5_OPT_A
        |=> !port5_option_a_pin_oe_n && port5_option_b_pin_oe_n)
        else $error("port 5 option A pin not driven");
    a_p6_opt_b: assert property (split_en_ff[`P6_BIT] && p6_sel_ff == `P6_OPT_B
        |=> !port6_option_b_pin_oe_n && port6_option_a_pin_oe_n)
        else $error("port 6 option B pin not driven");
    a_p6_split_idle: assert property (!split_en_ff[`P6_BIT] |=> port6_option_a_pin_oe_n
        && port6_option_b_pin_oe_n)
        else $error("split pin driven while port 6 not split");
    a_p6_reset_low: assert property (wd6.resetting
        |=> !port6_option_a_pin && !port6_option_b_pin)
        else $error("split power not low during port 6 link reset");
    a_enable_readback: assert property (cfg_rd && cfg_addr == `SPLIT_ENABLE_ADDR
        |=> cfg_rvalid && cfg_rdata == $past(split_en_ff))
        else $error("split enable read back wrong");
    a_zero_no_pulse: assert property (eff_timeout == 8'h00 && !link_reset_active[0]
        |=> !link_reset_active[0])
        else $error("link reset started with timeout off");
endmodule

// [test/ss_device_model.sv]
/*
 Behavioural embedded SuperSpeed device behind an external power switch.
 Assumes power is the resolved split power pin level, pulled low when undriven.
*/
module ss_device_model
(
    // Clock
    input wire logic clock,
    // Switched power and behaviour select
    input wire logic power,
    input wire logic [1:0] mode,
    input wire logic [3:0] stuck_state,
    // Link state seen by the hub, no overcurrent feedback at all
    output logic [3:0] link_state
);
    timeunit 1ns;
    timeprecision 1ps;
    int up_cnt = 0;
    int flap_cnt = 0;
    logic flap_ph = 1'b0;
    initial link_state = 4'h5;
    always @(posedge clock)
    begin
        up_cnt <= !power ? 0 : (up_cnt < 10 ? up_cnt + 1 : up_cnt);
        flap_cnt <= (flap_cnt == 29) ? 0 : flap_cnt + 1;
        if (flap_cnt == 29)
            flap_ph <= !flap_ph;
        case (mode)
            // Healthy: trains to U0 a while after power, detecting otherwise
            2'h0: link_state <= (power && up_cnt == 10) ? 4'h0 : 4'h5;
            // Broken device parked in one state
            2'h1: link_state <= stuck_state;
            // Flaps faster than any timeout window
            default: link_state <= flap_ph ? 4'h6 : 4'h5;
        endcase
    end
endmodule

// [test/port_split_ctrl_tb.sv]
/*
 Self-checking bench of the port split controller with two device models.
 Assumes TICK_CYCLES of 4, so one timeout count is 20 ticks of 4 cycles.
*/
`include "port_split_map.svh"

`define CHK(nm, e, g) \
    begin \
        checks_done++; \
        if ((g) !== (e)) \
        begin \
            error_cnt++; \
            $display("[FAIL] %s expected %0h seen %0h", nm, e, g); \
        end \
    end

module port_split_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK = 4;
    typedef struct { string nm; logic [7:0] val; } exp_t;
    logic clock = 1'b0, srst = 1'b1, cfg_stage = 1'b1, cfg_wr = 1'b0, cfg_rd = 1'b0;
    logic [15:0] cfg_addr = 16'h0000;
    logic [7:0] cfg_wdata = 8'h00, cfg_rdata, otp_en = 8'hFF, otp_s5 = 8'h05, otp_s6 = 8'h04;
    logic [7:0] otp_pw = 8'h0A, otp_to = 8'h00;
    logic cfg_rvalid, otp_load = 1'b0, otp_ovr = 1'b0;
    logic [1:0] port_power_req = 2'h0, legacy, link_reset_active, pwr, dev_mode = 2'h0;
    logic [3:0] p5_lts, p6_lts, oe_vec, pin_vec, stuck_state = 4'h5;
    logic a5, a5_oe_n, b5, b5_oe_n, a6, a6_oe_n, b6, b6_oe_n;
    logic [31:0] rnd;
    int error_cnt = 0, checks_done = 0, cycles = 0, seed = 91354, n;
    exp_t exp_q[$];
    exp_t got_e;

    always #10 clock = ~clock;
    assign oe_vec = {a5_oe_n, b5_oe_n, a6_oe_n, b6_oe_n};
    assign pin_vec = {a5, b5, a6, b6};
    // Switch enables are pulled low when a pin is released
    assign pwr[0] = (!a5_oe_n && a5) || (!b5_oe_n && b5);
    assign pwr[1] = (!a6_oe_n && a6) || (!b6_oe_n && b6);

    port_split_ctrl #(.TICK_CYCLES(TICK)) DUT (.clock(clock), .srst(srst),
        .cfg_stage(cfg_stage), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
        .otp_load(otp_load), .otp_split_enable(otp_en), .otp_p5_pin_select(otp_s5),
        .otp_p6_pin_select(otp_s6), .otp_pulse_width(otp_pw),
        .otp_timeout_override(otp_ovr), .otp_timeout_select(otp_to),
        .port_power_req(port_power_req), .p5_link_training_state_status(p5_lts),
        .p6_link_training_state_status(p6_lts), .legacy_port_power_ctrl(legacy),
        .port5_option_a_pin(a5), .port5_option_a_pin_oe_n(a5_oe_n),
        .port5_option_b_pin(b5), .port5_option_b_pin_oe_n(b5_oe_n),
        .port6_option_a_pin(a6), .port6_option_a_pin_oe_n(a6_oe_n),
        .port6_option_b_pin(b6), .port6_option_b_pin_oe_n(b6_oe_n),
        .link_reset_active(link_reset_active));
    ss_device_model dev5 (.clock(clock), .power(pwr[0]), .mode(dev_mode),
        .stuck_state(stuck_state), .link_state(p5_lts));
    ss_device_model dev6 (.clock(clock), .power(pwr[1]), .mode(dev_mode),
        .stuck_state(stuck_state), .link_state(p6_lts));

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Strobes drop with a spare edge after, so calls may follow back to back
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        cfg_addr = a;
        cfg_wdata = d;
        cfg_wr = 1'b1;
        @(negedge clock);
        cfg_wr = 1'b0;
        @(negedge clock);
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] v, input string nm);
        exp_q.push_back(exp_t'{nm, v});
        cfg_addr = a;
        cfg_rd = 1'b1;
        @(negedge clock);
        cfg_rd = 1'b0;
        @(negedge clock);
    endtask

    task automatic wait_pulse(input int p, input int limit, output int k);
        k = 0;
        while (link_reset_active[p] !== 1'b1 && k < limit)
        begin
            @(negedge clock);
            k++;
        end
    endtask

    task automatic expect_quiet(input int p, input int limit);
        int k;
        wait_pulse(p, limit, k);
        `CHK("no link reset", 1'b0, link_reset_active[p])
    endtask

    task automatic pulse_test(input int p, input logic [7:0] w);
        int k;
        int len;
        wr(`PULSE_WIDTH_ADDR, w);
        wr(`SPLIT_ENABLE_ADDR, 8'h00);
        stuck_state = p ? 4'h8 : 4'h9;
        wr(`SPLIT_ENABLE_ADDR, p ? 8'h40 : 8'h20);
        // Second round shows the watchdog restarting after each expiry
        repeat (2)
        begin
            wait_pulse(p, 200, k);
            `CHK("expiry in window", 1'b1, k >= 72 && k <= 92)
            repeat (2) @(negedge clock);
            `CHK("power low in pulse", 1'b0, pwr[p])
            len = 2;
            while (link_reset_active[p] === 1'b1 && len < 400)
            begin
                @(negedge clock);
                len++;
            end
            k = (35 + int'(w)) * TICK;
            `CHK("pulse length", 1'b1, len >= k - 4 && len <= k + 4)
            repeat (2) @(negedge clock);
            `CHK("power back after pulse", 1'b1, pwr[p])
        end
    endtask

    always @(negedge clock)
    begin
        if (cfg_rvalid === 1'b1)
        begin
            if (exp_q.size() == 0)
                `CHK("unexpected read", 1'b0, 1'b1)
            else
            begin
                got_e = exp_q.pop_front();
                `CHK(got_e.nm, got_e.val, cfg_rdata)
            end
        end
    end

    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 10000)
        begin
            error_cnt++;
            $display("[FAIL] run length expected 10000 seen %0d", cycles);
            summarize();
        end
    end

    initial
    begin
        static logic [7:0] s5 [4] = '{8'h42, 8'h05, 8'h00, 8'h42};
        static logic [7:0] s6 [4] = '{8'h06, 8'h04, 8'h00, 8'h06};
        static logic [7:0] en [4] = '{8'h60, 8'h60, 8'h60, 8'h20};
        static logic [3:0] eoe [4] = '{4'h5, 4'hA, 4'hF, 4'h7};
        repeat (10) @(negedge clock);
        srst = 1'b0;
        `CHK("pins released", 4'hF, oe_vec)
        rd(`SPLIT_ENABLE_ADDR, 8'h00, "split enable reset");
        rd(`P5_PIN_SEL_ADDR, 8'h42, "p5 select reset");
        rd(`P6_PIN_SEL_ADDR, 8'h06, "p6 select reset");
        rd(`TIMEOUT_SEL_ADDR, 8'h05, "timeout reset");
        rd(`PULSE_WIDTH_ADDR, 8'h05, "pulse width reset");
        rd(16'h4170, 8'h00, "unmapped read");
        wr(`SPLIT_ENABLE_ADDR, 8'hFF);
        rd(`SPLIT_ENABLE_ADDR, 8'h60, "only ports 5 and 6");
        wr(`SPLIT_ENABLE_ADDR, 8'h01);
        rd(`SPLIT_ENABLE_ADDR, 8'h00, "bit 0 read only");
        cfg_stage = 1'b0;
        wr(`TIMEOUT_SEL_ADDR, 8'h01);
        cfg_stage = 1'b1;
        rd(`TIMEOUT_SEL_ADDR, 8'h05, "write outside config");
        wr(`TIMEOUT_SEL_ADDR, 8'h01);
        rd(`TIMEOUT_SEL_ADDR, 8'h01, "timeout written");
        $display("test registers done");
        for (int i = 0; i < 4; i++)
        begin
            wr(`P5_PIN_SEL_ADDR, s5[i]);
            wr(`P6_PIN_SEL_ADDR, s6[i]);
            wr(`SPLIT_ENABLE_ADDR, en[i]);
            repeat (3) @(negedge clock);
            `CHK("pin routing", eoe[i], oe_vec)
            `CHK("routed pins high", 4'hF, pin_vec | oe_vec)
        end
        wr(`SPLIT_ENABLE_ADDR, 8'h60);
        repeat (8)
        begin
            rnd = $random(seed);
            port_power_req = rnd[1:0];
            @(negedge clock);
            `CHK("legacy power", port_power_req, legacy)
        end
        $display("test routing done");
        dev_mode = 2'h1;
        pulse_test(0, 8'h00);
        rnd = $random(seed);
        pulse_test(1, {4'h0, rnd[3:0]});
        $display("test link reset done");
        for (int s = 3; s <= 10; s++)
        begin
            wr(`SPLIT_ENABLE_ADDR, 8'h00);
            stuck_state = 4'(s);
            wr(`SPLIT_ENABLE_ADDR, 8'h20);
            wait_pulse(0, 100, n);
            `CHK("stuck state list", s >= 4 && s <= 9, link_reset_active[0])
        end
        wr(`SPLIT_ENABLE_ADDR, 8'h00);
        stuck_state = 4'h5;
        wr(`TIMEOUT_SEL_ADDR, 8'h00);
        wr(`SPLIT_ENABLE_ADDR, 8'h20);
        expect_quiet(0, 150);
        wr(`SPLIT_ENABLE_ADDR, 8'h00);
        wr(`TIMEOUT_SEL_ADDR, 8'h01);
        dev_mode = 2'h2;
        wr(`SPLIT_ENABLE_ADDR, 8'h20);
        expect_quiet(0, 250);
        $display("test stuck detection done");
        dev_mode = 2'h1;
        otp_ovr = 1'b1;
        otp_load = 1'b1;
        @(negedge clock);
        otp_load = 1'b0;
        rd(`SPLIT_ENABLE_ADDR, 8'h60, "otp split enable");
        rd(`P5_PIN_SEL_ADDR, 8'h05, "otp p5 select");
        rd(`P6_PIN_SEL_ADDR, 8'h04, "otp p6 select");
        rd(`PULSE_WIDTH_ADDR, 8'h0A, "otp pulse width");
        expect_quiet(0, 150);
        $display("test otp done");
        `CHK("reads pending", 0, exp_q.size())
        summarize();
    end
endmodule
